// ===== bench/conv_model.sv
// Purpose: behavioural converter answering each start with one done pulse
// Assumes: one conversion outstanding at a time
// Notes:   code is 0x100 plus channel; idle code toggles so it is never stale
`timescale 1ns/1ns
module conv_model
  import adc_sched_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] lat,
  input  wire conv_req_s  conv_req,
  output conv_rsp_s       conv_rsp
);
  logic [7:0] cnt;
  logic       busy;
  logic [2:0] ch;

  // latency set by the bench, so answers come promptly or slowly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_rsp <= '0;
      cnt      <= 8'h00;
      busy     <= 1'b0;
      ch       <= 3'h0;
    end else begin
      conv_rsp.done <= 1'b0;
      conv_rsp.code <= ~conv_rsp.code;  // no hold once done has gone
      if (conv_req.start) begin
        busy <= 1'b1;
        cnt  <= lat;
        ch   <= conv_req.channel;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
        if (cnt <= 8'h01) begin
          busy          <= 1'b0;
          conv_rsp.done <= 1'b1;
          conv_rsp.code <= 10'h100 + {7'h00, ch};
        end
      end
    end
  end
endmodule

// ===== bench/tb_top.sv
// Purpose: register bus host plus pwm source around the scheduler
// Assumes: pwm period 8400 cycles, well under the supported rate
// Notes:   monitor duty is measured over whole monitor periods
`timescale 1ns/1ns
module tb_top;
  import adc_sched_pkg::*;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, v, h;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        pwm_command_input = 0, driver_enabled = 1, fault_active = 0;
  logic        warn_event = 0, fault_event = 0, short_ctl_enable, pwm_q = 0;
  logic        fault_alarm_n_o, fault_alarm_n_oe_n, warning_alarm_n_o, warning_alarm_n_oe_n;
  logic [7:0]  lat = 8'h28;
  conv_req_s   conv_req;
  conv_rsp_s   conv_rsp;
  logic [31:0] seq[$], gaps[$], gap = 0, ord[7] = '{0, 2, 4, 1, 3, 5, 6};
  int          num_errors = 0, n_compared = 0;

  always #2 clk = ~clk;

  pwm_synced_adc_scheduler DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pwm_command_input(pwm_command_input), .driver_enabled(driver_enabled),
    .fault_active(fault_active), .warn_event(warn_event), .fault_event(fault_event),
    .conv_req(conv_req), .conv_rsp(conv_rsp), .short_ctl_enable(short_ctl_enable),
    .fault_alarm_n_o(fault_alarm_n_o), .fault_alarm_n_oe_n(fault_alarm_n_oe_n),
    .warning_alarm_n_o(warning_alarm_n_o), .warning_alarm_n_oe_n(warning_alarm_n_oe_n));

  conv_model partner (.clk(clk), .rst_n(rst_n), .lat(lat), .conv_req(conv_req),
    .conv_rsp(conv_rsp));

  // log each start with pwm level and cycles since the last pwm change
  always @(posedge clk) begin
    pwm_q <= pwm_command_input;
    gap   <= (pwm_command_input !== pwm_q) ? 32'h0 : gap + 32'h1;
    if (conv_req.start === 1'b1) begin
      seq.push_back({28'h0, pwm_command_input, conv_req.channel});
      gaps.push_back(gap);
    end
  end

  task automatic conclude;
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, v);
    chk(what, exp, v);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // one switching period at a legal rate, equal high and low phases
  task automatic pwm_cycle;
    pwm_command_input <= 1'b1;
    repeat (4200) @(posedge clk);
    pwm_command_input <= 1'b0;
    repeat (4200) @(posedge clk);
  endtask

  task automatic clr;
    seq.delete();
    gaps.delete();
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("short_ctl_enable", 1, short_ctl_enable);
    rdchk("hyb_period", OFF_HYB_PER, {8'h00, HYB_PER_RST});
    rdchk("unmapped", 8'h3C, 32'h0);
    wr(OFF_ANALOG_CFG, 32'h1);
    repeat (2) @(posedge clk);
    chk("short_ctl_enable", 0, short_ctl_enable);
    // edge mode, delay 16, all channels in high set, none in low set
    wr(OFF_CHAN_SEL, 32'h0000007F);
    wr(OFF_CONV_CFG, 32'h00001003);
    clr();
    pwm_cycle();
    for (int i = 0; i < 7; i++) chk("edge_order", ord[i] | 32'h8, seq[i]);
    chk("edge_wrap", 32'h8, seq[7]);
    chk("edge_delay", 1, gaps[0] >= 14);
    rdchk("stamp", OFF_STATUS, 32'h00020001);
    for (int i = 0; i < 7; i++)
      rdchk("result", 8'(OFF_RESULT0 + 4 * i), 32'h00010100 + i);
    fault_active <= 1'b1;
    pwm_cycle();
    bus(1'b0, OFF_STATUS, 32'h0, v);
    chk("stamp_fault", 1, v[15:0]);
    fault_active <= 1'b0;
    wr(OFF_CONV_CFG, 32'h00001002);
    clr();
    pwm_cycle();
    chk("idle_starts", 0, 32'(seq.size()));
    wr(OFF_PIN_CFG, 32'h1);
    wr(OFF_MON_CFG, 32'h100);
    // center mode, die temp while high, input 1 while low, fast answers
    lat <= 8'h03;
    wr(OFF_CHAN_SEL, 32'h00000140);
    wr(OFF_CONV_CFG, 32'h00001001);
    pwm_cycle();
    pwm_cycle();
    clr();
    pwm_cycle();
    chk("center_count", 2, 32'(seq.size()));
    chk("center_high", 32'hE, seq[0]);
    chk("center_low", 32'h0, seq[1]);
    for (int k = 0; k < 2; k++) chk("center_time", 1, gaps[k] >= 2090 && gaps[k] <= 2115);
    wr(OFF_CONV_CFG, 32'h00001005);
    pwm_cycle();
    bus(1'b0, OFF_STATUS, 32'h0, v);
    chk("hybrid_edge", 1, v[ST_EDGE_BIT]);
    wr(OFF_HYB_PER, 32'h00003000);
    pwm_cycle();
    bus(1'b0, OFF_STATUS, 32'h0, v);
    chk("hybrid_center", 0, v[ST_EDGE_BIT]);
    // fault halts conversions; monitor keeps the last die temp code
    fault_active <= 1'b1;
    repeat (20) @(posedge clk);
    for (int f = 0; f < 4; f++) begin
      wr(OFF_MON_CFG, 32'h100 | f);
      repeat (1023 << f) @(posedge clk);
      h = 0;
      repeat (1023 << f) begin
        @(posedge clk);
        h = h + warning_alarm_n_oe_n;
      end
      chk("monitor_duty", 32'h106 << f, h);
    end
    chk("fault_pin_idle", 1, fault_alarm_n_oe_n);
    warn_event <= 1'b1;
    repeat (3) @(posedge clk);
    chk("fault_pin_warn", 0, fault_alarm_n_oe_n);
    chk("alarm_levels", 0, {fault_alarm_n_o, warning_alarm_n_o});
    wr(OFF_PIN_CFG, 32'h0);
    repeat (2) @(posedge clk);
    chk("warn_pin_warn", 0, warning_alarm_n_oe_n);
    chk("fault_pin_free", 1, fault_alarm_n_oe_n);
    conclude();
  end
endmodule

// ===== rtl/adc_sched_pkg.sv
// Purpose: shared constants, types and register map of the converter scheduler
// Assumes: AHB-Lite register access, 32-bit words, one clock of 250 MHz
// Notes:   channel index 0..5 are sense inputs 1..6, index 6 is die temperature
//
// Summary of operation
// - latest result per channel always readable
// - each result tagged with pwm cycle count
// - stamp counts pwm rises when enabled
// - stamp frozen during fault or no edges
// - code step equals 3.519 mV
// - inputs five, six reserved unless mux set
// - convert only while converter enabled
// - separate high and low phase channel sets
// - fixed order 1,3,5,2,4,6, die temperature
// - mode field: center, edge, hybrid
// - center from previous phase length
// - center mode: one conversion per phase
// - edge mode waits sample delay first
// - edge mode: rise high set, fall low
// - edge mode cycles until next edge
// - hybrid picks edge above period threshold
// - monitor output duty follows value
// - monitor shares warning pin, warnings reroute
// - monitor frequency from four settings
// - monitor channel select bits, one advised
// - monitor holds last good value on fault
package adc_sched_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CONV_CFG   = 8'h00;
  localparam logic [7:0] OFF_CHAN_SEL   = 8'h04;
  localparam logic [7:0] OFF_ANALOG_CFG = 8'h08;
  localparam logic [7:0] OFF_PIN_CFG    = 8'h0C;
  localparam logic [7:0] OFF_MON_CFG    = 8'h10;
  localparam logic [7:0] OFF_HYB_PER    = 8'h14;
  localparam logic [7:0] OFF_STATUS     = 8'h18;
  localparam logic [7:0] OFF_RESULT0    = 8'h20;
  localparam logic [7:0] OFF_RESULT6    = 8'h38;

  // widths
  localparam int NUM_CH  = 7;
  localparam int CODE_W  = 10;
  localparam int STAMP_W = 16;
  localparam int LEN_W   = 24;
  localparam int DLY_W   = 8;

  // field positions
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_MODE_LSB  = 1;
  localparam int CFG_DLY_LSB   = 8;
  localparam int SEL_LOW_LSB   = 8;
  localparam int MON_SEL_LSB   = 2;
  localparam int RES_STAMP_LSB = 16;
  localparam int ST_BUSY_BIT   = 16;
  localparam int ST_EDGE_BIT   = 17;
  localparam int ST_PWM_BIT    = 18;

  // reset values and fixed figures
  localparam logic [LEN_W-1:0]  HYB_PER_RST = 24'h002000;
  localparam logic [LEN_W-1:0]  LEN_MAX     = 24'hFFFFFF;
  localparam logic [CODE_W-1:0] MON_CNT_MAX = 10'h3FE;  // period 1023 steps
  localparam logic [6:0]        ASC_CH_MASK = 7'h30;    // inputs five and six
  localparam logic [2:0]        RR_LAST     = 3'h6;
  localparam logic [3:0]        PRESC_ONE   = 4'h1;
  // visit order, position 0 in the low bits
  localparam logic [20:0] RR_ORDER = {3'h6, 3'h5, 3'h3, 3'h1, 3'h4, 3'h2, 3'h0};

  typedef enum logic [1:0] {
    MODE_CENTER = 2'h0,
    MODE_EDGE   = 2'h1,
    MODE_HYBRID = 2'h2
  } samp_mode_e;

  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_DELAY  = 5'b00010,
    S_RUN    = 5'b00100,
    S_CENTER = 5'b01000,
    S_DONE   = 5'b10000
  } sched_state_e;

  typedef struct packed {
    logic       start;
    logic [2:0] channel;
  } conv_req_s;

  typedef struct packed {
    logic              done;
    logic [CODE_W-1:0] code;
  } conv_rsp_s;

  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    logic [CODE_W-1:0]  code;
  } result_word_s;

endpackage

// ===== rtl/pwm_synced_adc_scheduler.sv
// Purpose: schedules conversions against the pwm command and keeps results
// Assumes: converter answers every start with one done pulse
// Notes:   codes are 3.519 mV per step; scaling is left to software
`timescale 1ns/1ns
module pwm_synced_adc_scheduler (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire logic                     pwm_command_input,
  input  wire logic                     driver_enabled,
  input  wire logic                     fault_active,
  input  wire logic                     warn_event,
  input  wire logic                     fault_event,
  output adc_sched_pkg::conv_req_s      conv_req,
  input  wire adc_sched_pkg::conv_rsp_s conv_rsp,
  output logic                          short_ctl_enable,
  output logic                          fault_alarm_n_o,
  output logic                          fault_alarm_n_oe_n,
  output logic                          warning_alarm_n_o,
  output logic                          warning_alarm_n_oe_n
);
  import adc_sched_pkg::*;

  logic               rst_meta_reg;
  logic               rst_sync_n;
  logic               adc_en_reg;
  logic [1:0]         mode_reg;
  logic [DLY_W-1:0]   dly_reg;
  logic [6:0]         hi_sel_reg;
  logic [6:0]         lo_sel_reg;
  logic               asc_mux_reg;
  logic               pin_mux_reg;
  logic [1:0]         mon_freq_reg;
  logic [6:0]         mon_sel_reg;
  logic [LEN_W-1:0]   hyb_thr_reg;
  logic               wr_pend_reg;
  logic               rd_pend_reg;
  logic [7:0]         addr_reg;
  logic [31:0]        rd_word;
  logic               pwm_q_reg;
  logic [LEN_W-1:0]   phase_cnt_reg;
  logic [LEN_W-1:0]   hi_len_reg;
  logic [LEN_W-1:0]   lo_len_reg;
  logic [STAMP_W-1:0] stamp_reg;
  logic [STAMP_W-1:0] sample_stamp_reg;
  sched_state_e       state_reg;
  sched_state_e       state_next;
  logic [DLY_W-1:0]   dly_cnt_reg;
  logic               busy_reg;
  logic [2:0]         hi_pos_reg;
  logic [2:0]         lo_pos_reg;
  logic [2:0]         cur_ch_reg;
  logic [CODE_W-1:0]  duty_reg;
  logic [3:0]         presc_reg;
  logic [CODE_W-1:0]  mon_cnt_reg;
  logic               mon_out_reg;
  logic [1:0]         phase_convs_reg;
  logic               rise;
  logic               fall;
  logic               any_edge;
  logic               run_ok;
  logic               use_edge;
  logic [6:0]         act_set;
  logic [3:0]         pick;
  logic               at_center;
  logic               start_now;
  logic [2:0]         rd_idx;
  result_word_s       mem_rd;
  result_word_s       mem_wr;

  // next selected position after pos in the fixed visit order
  function automatic logic [3:0] next_pick(input logic [6:0] sel, input logic [2:0] pos);
    logic [3:0] res;
    logic [2:0] p;
    res = '0;
    for (int i = 1; i <= NUM_CH; i++) begin
      p = 3'((int'(pos) + i) % NUM_CH);
      if (!res[3] && sel[RR_ORDER[int'(p) * 3 +: 3]]) begin
        res = {1'b1, p};
      end
    end
    return res;
  endfunction

  // result slot of a bus address; addresses outside the result words give slot 0
  function automatic logic [2:0] slot_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_RESULT0;
    if (a < OFF_RESULT0 || a > OFF_RESULT6) begin
      return 3'h0;
    end
    return d[4:2];
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // ahb data phase tracking; reads take one wait state for the memory
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= '0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= '0;
    end else begin
      wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
      rd_pend_reg <= hsel && htrans[1] && hready && !hwrite;
      if (hsel && htrans[1] && hready) begin
        addr_reg <= haddr[7:0];
      end
      if (hsel && htrans[1] && hready && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout <= 1'b1;
        hrdata    <= rd_word;
      end
    end
  end

  // read decode; unmapped words read zero
  always_comb begin
    rd_word = '0;
    if (addr_reg == OFF_CONV_CFG) begin
      rd_word[CFG_EN_BIT] = adc_en_reg;
      rd_word[CFG_MODE_LSB +: 2] = mode_reg;
      rd_word[CFG_DLY_LSB +: DLY_W] = dly_reg;
    end else if (addr_reg == OFF_CHAN_SEL) begin
      rd_word[6:0] = hi_sel_reg;
      rd_word[SEL_LOW_LSB +: 7] = lo_sel_reg;
    end else if (addr_reg == OFF_ANALOG_CFG) begin
      rd_word[0] = asc_mux_reg;
    end else if (addr_reg == OFF_PIN_CFG) begin
      rd_word[0] = pin_mux_reg;
    end else if (addr_reg == OFF_MON_CFG) begin
      rd_word[1:0] = mon_freq_reg;
      rd_word[MON_SEL_LSB +: 7] = mon_sel_reg;
    end else if (addr_reg == OFF_HYB_PER) begin
      rd_word[LEN_W-1:0] = hyb_thr_reg;
    end else if (addr_reg == OFF_STATUS) begin
      rd_word[STAMP_W-1:0] = stamp_reg;
      rd_word[ST_BUSY_BIT] = busy_reg;
      rd_word[ST_EDGE_BIT] = use_edge;
      rd_word[ST_PWM_BIT] = pwm_q_reg;
    end else if (addr_reg >= OFF_RESULT0 && addr_reg <= OFF_RESULT6 && addr_reg[1:0] == 2'h0) begin
      rd_word[CODE_W-1:0] = mem_rd.code;
      rd_word[RES_STAMP_LSB +: STAMP_W] = mem_rd.stamp;
    end
  end

  // configuration writes, taken at the end of the data phase
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      adc_en_reg   <= 1'b0;
      mode_reg     <= MODE_CENTER;
      dly_reg      <= '0;
      hi_sel_reg   <= '0;
      lo_sel_reg   <= '0;
      asc_mux_reg  <= 1'b0;
      pin_mux_reg  <= 1'b0;
      mon_freq_reg <= '0;
      mon_sel_reg  <= '0;
      hyb_thr_reg  <= HYB_PER_RST;
    end else if (wr_pend_reg) begin
      if (addr_reg == OFF_CONV_CFG) begin
        adc_en_reg <= hwdata[CFG_EN_BIT];
        mode_reg   <= hwdata[CFG_MODE_LSB +: 2];
        dly_reg    <= hwdata[CFG_DLY_LSB +: DLY_W];
      end else if (addr_reg == OFF_CHAN_SEL) begin
        hi_sel_reg <= hwdata[6:0];
        lo_sel_reg <= hwdata[SEL_LOW_LSB +: 7];
      end else if (addr_reg == OFF_ANALOG_CFG) begin
        asc_mux_reg <= hwdata[0];
      end else if (addr_reg == OFF_PIN_CFG) begin
        pin_mux_reg <= hwdata[0];
      end else if (addr_reg == OFF_MON_CFG) begin
        mon_freq_reg <= hwdata[1:0];
        mon_sel_reg  <= hwdata[MON_SEL_LSB +: 7];
      end else if (addr_reg == OFF_HYB_PER) begin
        hyb_thr_reg <= hwdata[LEN_W-1:0];
      end
    end
  end

  // scheduling conditions; reserved mode code behaves as center
  assign rise      = pwm_command_input && !pwm_q_reg;
  assign fall      = !pwm_command_input && pwm_q_reg;
  assign any_edge  = rise || fall;
  assign run_ok    = adc_en_reg && !fault_active;
  assign use_edge  = (mode_reg == MODE_EDGE) ||
                     (mode_reg == MODE_HYBRID &&
                      ({1'b0, hi_len_reg} + {1'b0, lo_len_reg}) > {1'b0, hyb_thr_reg});
  assign act_set   = (pwm_q_reg ? hi_sel_reg : lo_sel_reg) &
                     (asc_mux_reg ? 7'h7F : ~ASC_CH_MASK);
  assign pick      = next_pick(act_set, pwm_q_reg ? hi_pos_reg : lo_pos_reg);
  assign at_center = phase_cnt_reg >= ((pwm_q_reg ? hi_len_reg : lo_len_reg) >> 1);
  assign start_now = !any_edge && run_ok && !busy_reg && pick[3] &&
                     ((state_reg == S_RUN && use_edge) || // hybrid fallback stops the run
                      (state_reg == S_CENTER && at_center));

  // phase length measurement, kept for the next cycle's center
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwm_q_reg     <= 1'b0;
      phase_cnt_reg <= '0;
      hi_len_reg    <= '0;
      lo_len_reg    <= '0;
    end else begin
      pwm_q_reg <= pwm_command_input;
      if (any_edge) begin
        phase_cnt_reg <= '0;
      end else if (phase_cnt_reg != LEN_MAX) begin
        phase_cnt_reg <= phase_cnt_reg + 1'b1; // saturates on a stuck input
      end
      if (fall) begin
        hi_len_reg <= phase_cnt_reg;
      end
      if (rise) begin
        lo_len_reg <= phase_cnt_reg;
      end
    end
  end

  // time stamp counts pwm rises while converter and driver are enabled; frozen in fault or without edges
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stamp_reg <= '0;
    end else if (rise && adc_en_reg && driver_enabled && !fault_active) begin
      stamp_reg <= stamp_reg + 1'b1;
    end
  end

  // scheduler state: every edge restarts the phase plan
  always_comb begin
    state_next = state_reg;
    if (!run_ok) begin
      state_next = S_IDLE;
    end else if (any_edge) begin
      state_next = use_edge ? S_DELAY : S_CENTER;
    end else begin
      case (state_reg)
        S_DELAY:  if (dly_cnt_reg == '0) state_next = S_RUN;
        S_CENTER: if (start_now) state_next = S_DONE;
        default:  state_next = state_reg; // run cycles until the next edge
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg   <= S_IDLE;
      dly_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (any_edge) begin
        dly_cnt_reg <= dly_reg;
      end else if (state_reg == S_DELAY && dly_cnt_reg != '0) begin
        dly_cnt_reg <= dly_cnt_reg - 1'b1;
      end
    end
  end

  // conversion issue and completion
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      conv_req         <= '0;
      busy_reg         <= 1'b0;
      hi_pos_reg       <= RR_LAST;
      lo_pos_reg       <= RR_LAST;
      cur_ch_reg       <= '0;
      sample_stamp_reg <= '0;
    end else begin
      conv_req.start <= start_now;
      if (start_now) begin
        conv_req.channel <= RR_ORDER[int'(pick[2:0]) * 3 +: 3];
        cur_ch_reg       <= RR_ORDER[int'(pick[2:0]) * 3 +: 3];
        sample_stamp_reg <= stamp_reg;
        busy_reg         <= 1'b1;
        if (pwm_q_reg) begin
          hi_pos_reg <= pick[2:0];
        end else begin
          lo_pos_reg <= pick[2:0];
        end
      end else if (conv_rsp.done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  assign mem_wr = '{stamp: sample_stamp_reg, code: conv_rsp.code};
  assign rd_idx = slot_of(haddr[7:0]);

  result_mem u_results (
    .clk     (clk),
    .rst_n   (rst_sync_n),
    .wr_en   (conv_rsp.done && busy_reg),
    .wr_idx  (cur_ch_reg),
    .wr_data (mem_wr),
    .rd_idx  (rd_idx),
    .rd_data (mem_rd)
  );

  // monitor duty: last good code of a selected channel
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      duty_reg <= '0;
    end else if (conv_rsp.done && busy_reg && !fault_active && mon_sel_reg[cur_ch_reg]) begin
      duty_reg <= conv_rsp.code;
    end
  end

  // monitor pwm; keeps running in fault so the held value stays visible
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      presc_reg   <= '0;
      mon_cnt_reg <= '0;
      mon_out_reg <= 1'b0;
    end else begin
      if (presc_reg >= (PRESC_ONE << mon_freq_reg) - PRESC_ONE) begin
        presc_reg   <= '0;
        mon_cnt_reg <= (mon_cnt_reg >= MON_CNT_MAX) ? '0 : mon_cnt_reg + 1'b1;
      end else begin
        presc_reg <= presc_reg + 1'b1;
      end
      mon_out_reg <= mon_cnt_reg < duty_reg;
    end
  end

  // open-drain pins; enable low pulls the pin low
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fault_alarm_n_o      <= 1'b0;
      fault_alarm_n_oe_n   <= 1'b1;
      warning_alarm_n_o    <= 1'b0;
      warning_alarm_n_oe_n <= 1'b1;
      short_ctl_enable     <= 1'b1;
    end else begin
      fault_alarm_n_o      <= 1'b0;
      warning_alarm_n_o    <= 1'b0;
      fault_alarm_n_oe_n   <= !(fault_event || (pin_mux_reg && warn_event));
      warning_alarm_n_oe_n <= pin_mux_reg ? mon_out_reg : !warn_event;
      short_ctl_enable     <= !asc_mux_reg;
    end
  end

  // phase conversion count for checking the center schedule
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_convs_reg <= '0;
    end else if (any_edge) begin
      phase_convs_reg <= '0;
    end else if (start_now && phase_convs_reg != 2'h3) begin
      phase_convs_reg <= phase_convs_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence stamp_rise;
    rise && adc_en_reg && driver_enabled && !fault_active;
  endsequence

  sequence good_done;
    conv_rsp.done && busy_reg && !fault_active && mon_sel_reg[cur_ch_reg];
  endsequence

  chk_stamp_count: assert property (stamp_rise |=> stamp_reg == $past(stamp_reg) + 1'b1)
    else $error("stamp did not advance on enabled rise");
  chk_stamp_freeze: assert property (fault_active |=> $stable(stamp_reg))
    else $error("stamp moved during fault");
  chk_conv_enable: assert property (conv_req.start |-> $past(adc_en_reg) && !$past(fault_active))
    else $error("conversion started while disabled");
  chk_center_once: assert property (start_now && !use_edge |-> phase_convs_reg == 2'h0)
    else $error("second center conversion in one phase");
  chk_edge_delay: assert property (any_edge && run_ok && use_edge |=>
                                   state_reg == S_DELAY && dly_cnt_reg == $past(dly_reg))
    else $error("edge mode started without delay");
  chk_asc_exclude: assert property (start_now && !asc_mux_reg |=>
                                    conv_req.channel != 3'h4 && conv_req.channel != 3'h5)
    else $error("shared input converted while reserved");
  chk_warn_reroute: assert property (pin_mux_reg && warn_event |=> !fault_alarm_n_oe_n)
    else $error("warning not rerouted to fault pin");
  chk_duty_follow: assert property (good_done |=> duty_reg == $past(conv_rsp.code))
    else $error("duty did not take the new code");
  chk_duty_hold: assert property (fault_active |=> $stable(duty_reg))
    else $error("duty changed during fault");

endmodule

// ===== rtl/result_mem.sv
// Purpose: per-channel result store, one word per channel
// Assumes: indices below the channel count
// Notes:   read data is registered, so a read costs one cycle
`timescale 1ns/1ns
module result_mem (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        wr_en,
  input  wire logic [2:0]                  wr_idx,
  input  wire adc_sched_pkg::result_word_s wr_data,
  input  wire logic [2:0]                  rd_idx,
  output adc_sched_pkg::result_word_s      rd_data
);
  import adc_sched_pkg::*;

  result_word_s mem_reg [NUM_CH];

  // newest result overwrites the channel slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_idx];
    end
  end

endmodule
